// ### hdl/vlc_link_control.v
/*
 write-only link control register of a vpw byte link with its control effects:
 response sequencing flags, skip-to-idle, power down, high speed, clock divider.
 assumes the serial engine pulses xfer_done after each 8-bit control exchange
 with the received byte on ctrl_byte, and reports bus events as one-cycle pulses.
*/
`timescale 1ns/10ps
`include "vlc_regs.vh"
// Behaviour
// - eight-bit control register, reset clears all
// - host can set but never clear upper four bits
// - response request cleared on success or idle
// - response byte captured during crc exchange
// - lost arbitration: one transmission, clear once
// - multi-byte response appends crc after last
// - lost arbitration stops further response bytes
// - multi without request sends nothing
// - skip-to-idle resets, output low, idle high
// - idle pin held six microseconds minimum
// - no unsolicited transfers until next idle
// - power down halts, wakes on events
// - power down accepted only idle-low or first
// - premature wake restarts with idle pulse
// - high speed decodes quarter time, blocks output
// - high speed write gated, applied next edge
// - high speed cleared by break or write
// - divide select maps to divider ratio
// - reset forces divide-by-sixteen until first exchange
// - divide select kept through power down
// - exchange loads control, returns status
// - long byte-ready marks final byte
module vlc_link_control (
   // clock and reset
   input  wire       clk,
   input  wire       resetn,
   // serial exchange side
   input  wire       xfer_done,
   input  wire [7:0] ctrl_byte,
   input  wire       first_after_break,
   // bus events from codec and sequencer
   input  wire       bus_idle_det,
   input  wire       ifr_success,
   input  wire       arb_lost,
   input  wire       break_det,
   input  wire       rx_edge,
   input  wire       pd_abort,
   // pins seen from outside
   input  wire       bus_symbol_in,
   input  wire       exch_req_in,
   input  wire       byte_ready_in,
   // control outputs
   output reg  [7:0] ctrl_q,
   output reg        ifr_enable_q,
   output reg        ifr_multi_q,
   output reg        multi_status_q,
   output reg        tx_blocked_q,
   output reg        hs_active_q,
   output reg        idle_pin_q,
   output reg        unsol_hold_q,
   output reg        codec_passive_q,
   output reg        clk_gate_q,
   output reg  [4:0] div_ratio_q,
   output reg        tick_q
);
   localparam S_RUN  = 3'b001;
   localparam S_SKIP = 3'b010;
   localparam S_WAIT = 3'b100;
   localparam [8:0] SKIP_CYC = `VLC_SKIP_HOLD_CYC;
   localparam [8:0] RST_CYC  = `VLC_RESTART_CYC;

   reg  [2:0] state_q;
   reg  [8:0] cnt_q;
   reg        first_q;
   reg        aborted_q;
   localparam [2:0] PIN_IDLE = 3'b001;
   wire [2:0] pin_raw;
   wire [2:0] pin_lvl;
   wire       bi_lvl_q;
   wire       er_lvl_q;
   wire       br_lvl_q;
   reg        er_prev_q;
   reg  [4:0] dcnt_q;
   reg  [4:0] sel_ratio;
   wire       pin_ok = ~idle_pin_q | first_q;
   wire       wake = ~bi_lvl_q | (er_lvl_q & ~er_prev_q) | br_lvl_q;

   always @* begin
      case (ctrl_q[`VLC_DS_MSB:`VLC_DS_LSB])
         3'h0: sel_ratio = 5'h0c;
         3'h1: sel_ratio = 5'h06;
         3'h2: sel_ratio = 5'h0a;
         3'h3: sel_ratio = 5'h05;
         3'h4: sel_ratio = 5'h08;
         3'h5: sel_ratio = 5'h04;
         3'h6: sel_ratio = 5'h02;
         default: sel_ratio = 5'h01;
      endcase
   end

   // pin synchronisers, stages two and three agree
   assign pin_raw  = {byte_ready_in, exch_req_in, bus_symbol_in};
   assign bi_lvl_q = pin_lvl[0];
   assign er_lvl_q = pin_lvl[1];
   assign br_lvl_q = pin_lvl[2];
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         reg [2:0] stg_q;
         reg       lvl_q;
         always @(posedge clk) begin
            stg_q <= {stg_q[1:0], pin_raw[gi]};
            if (!resetn)
               lvl_q <= PIN_IDLE[gi];
            else if (stg_q[2] == stg_q[1])
               lvl_q <= stg_q[2];
         end
         assign pin_lvl[gi] = lvl_q;
      end
   endgenerate

   // exchange request edge history
   always @(posedge clk) begin
      if (!resetn)
         er_prev_q <= 1'b0;
      else
         er_prev_q <= er_lvl_q;
   end

   always @(posedge clk) begin
      if (!resetn) begin
         ctrl_q          <= `VLC_CTRL_RESET;
         first_q         <= 1'b1;
         state_q         <= S_RUN;
         cnt_q           <= 9'h000;
         aborted_q       <= 1'b0;
         multi_status_q  <= 1'b0;
         hs_active_q     <= 1'b0;
         idle_pin_q      <= 1'b1;
         unsol_hold_q    <= 1'b0;
         codec_passive_q <= 1'b1;
         clk_gate_q      <= 1'b0;
      end else begin
         if (xfer_done) begin
            ctrl_q[`VLC_BIT_IFR_REQ] <= ctrl_q[`VLC_BIT_IFR_REQ] | ctrl_byte[`VLC_BIT_IFR_REQ];
            ctrl_q[`VLC_BIT_MULTI]   <= ctrl_q[`VLC_BIT_MULTI] | ctrl_byte[`VLC_BIT_MULTI];
            if (ctrl_byte[`VLC_BIT_PDOWN] && pin_ok && !br_lvl_q)
               ctrl_q[`VLC_BIT_PDOWN] <= 1'b1;
            if (pin_ok && !(first_after_break && ctrl_byte[`VLC_BIT_HSPEED]))
               ctrl_q[`VLC_BIT_HSPEED] <= ctrl_byte[`VLC_BIT_HSPEED];
            ctrl_q[`VLC_DS_MSB:`VLC_DS_LSB] <= ctrl_byte[`VLC_DS_MSB:`VLC_DS_LSB];
            first_q         <= 1'b0;
            codec_passive_q <= 1'b0;
            multi_status_q <= ctrl_q[`VLC_BIT_MULTI] | ctrl_byte[`VLC_BIT_MULTI];
         end else begin
            if (ifr_success || bus_idle_det)
               ctrl_q[`VLC_BIT_IFR_REQ] <= 1'b0;
            if (bus_idle_det)
               ctrl_q[`VLC_BIT_MULTI] <= 1'b0;
            if (break_det)
               ctrl_q[`VLC_BIT_HSPEED] <= 1'b0;
            if (ctrl_q[`VLC_BIT_PDOWN] && (wake || pd_abort)) begin
               ctrl_q[`VLC_BIT_PDOWN] <= 1'b0;
               aborted_q <= pd_abort;
            end
         end
         clk_gate_q <= ctrl_q[`VLC_BIT_PDOWN] & ~wake & ~xfer_done;
         if (rx_edge)
            hs_active_q <= ctrl_q[`VLC_BIT_HSPEED];
         case (state_q)
            S_RUN: begin
               // restart pulse after aborted power down
               if (aborted_q && !ctrl_q[`VLC_BIT_PDOWN] && !xfer_done) begin
                  aborted_q  <= 1'b0;
                  idle_pin_q <= 1'b1;
                  cnt_q      <= RST_CYC;
                  state_q    <= S_SKIP;
               end else if (bus_idle_det && !codec_passive_q)
                  idle_pin_q <= 1'b0;
               else if (rx_edge)
                  idle_pin_q <= 1'b1;
            end
            S_SKIP: begin
               if (cnt_q != 9'h000)
                  cnt_q <= cnt_q - 9'h001;
               else if (bi_lvl_q) begin
                  idle_pin_q   <= 1'b0;
                  unsol_hold_q <= 1'b0;
                  ctrl_q[`VLC_BIT_SKIP] <= 1'b0;
                  state_q      <= S_RUN;
               end else
                  state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (bus_idle_det) begin
                  idle_pin_q   <= 1'b0;
                  unsol_hold_q <= 1'b0;
                  ctrl_q[`VLC_BIT_SKIP] <= 1'b0;
                  state_q      <= S_RUN;
               end
            end
            default: state_q <= S_RUN;
         endcase
         // skip request, new request wins over completion
         if (xfer_done && ctrl_byte[`VLC_BIT_SKIP]) begin
            ctrl_q[`VLC_BIT_SKIP] <= 1'b1;
            state_q      <= S_SKIP;
            cnt_q        <= SKIP_CYC;
            idle_pin_q   <= 1'b1;
            unsol_hold_q <= 1'b1;
         end
      end
   end

   // response sequencing flags
   always @(posedge clk) begin
      if (!resetn) begin
         ifr_enable_q <= 1'b0;
         ifr_multi_q  <= 1'b0;
         tx_blocked_q <= 1'b0;
      end else begin
         if (arb_lost)
            tx_blocked_q <= 1'b1;
         else if (bus_idle_det)
            tx_blocked_q <= 1'b0;
         ifr_enable_q <= ctrl_q[`VLC_BIT_IFR_REQ] & ~tx_blocked_q & ~ifr_success;
         ifr_multi_q  <= ctrl_q[`VLC_BIT_IFR_REQ] & ctrl_q[`VLC_BIT_MULTI];
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         div_ratio_q <= `VLC_DIV_RESET;
         dcnt_q      <= 5'h00;
         tick_q      <= 1'b0;
      end else begin
         // divider held until first exchange done
         if (!first_q)
            div_ratio_q <= sel_ratio;
         if (dcnt_q + 5'h01 >= div_ratio_q) begin
            dcnt_q <= 5'h00;
            tick_q <= ~clk_gate_q;
         end else begin
            dcnt_q <= dcnt_q + 5'h01;
            tick_q <= 1'b0;
         end
      end
   end
endmodule // vlc_link_control

// ### hdl/vlc_regs.vh
/*
 link control register constants: field positions, reset value, timings.
 assumes a 20 mhz system clock; included by the link control module.
*/
`ifndef VLC_REGS_VH
`define VLC_REGS_VH
// field positions
`define VLC_BIT_IFR_REQ    7
`define VLC_BIT_MULTI      6
`define VLC_BIT_SKIP       5
`define VLC_BIT_PDOWN      4
`define VLC_BIT_HSPEED     3
`define VLC_DS_MSB         2
`define VLC_DS_LSB         0
`define VLC_CTRL_RESET     8'h00
// divider forced during reset
`define VLC_DIV_RESET      5'h10
// timings in ns and in 20 mhz cycles, sized for the 9-bit counter
`define VLC_CLK_NS         50
`define VLC_SKIP_HOLD_NS   6000
`define VLC_SKIP_HOLD_CYC  9'h078
`define VLC_RESTART_NS     2000
`define VLC_RESTART_CYC    9'h028
`endif

// ### verification/vlc_props_properties.sv
/* checker: timing relations of the link control register outputs.
 assumes binding onto vlc_link_control, one clock, sync active-low reset. */
`timescale 1ns/10ps
module vlc_props (
   // watched ports
   input wire       clk, resetn, xfer_done, first_after_break, bus_idle_det,
   input wire       ifr_success, break_det, ifr_enable_q, idle_pin_q, unsol_hold_q,
   input wire       codec_passive_q,
   input wire [7:0] ctrl_byte, ctrl_q,
   input wire [4:0] div_ratio_q
);
   localparam [39:0] DT = {5'h01, 5'h02, 5'h04, 5'h08, 5'h05, 5'h0a, 5'h06, 5'h0c};
   reg [7:0] hold_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // cycles since a skip request was taken
   always @(posedge clk) begin
      if (!resetn) hold_q <= 8'h00;
      else if (xfer_done && ctrl_byte[5]) hold_q <= 8'h01;
      else if (hold_q != 8'h00 && hold_q < 8'h78) hold_q <= hold_q + 8'h01;
   end
   chk_div_select: assert property (xfer_done ##2 1'b1 |->
      div_ratio_q == DT[$past(ctrl_byte[2:0], 2) * 5 +: 5]) else $error("divider wrong");
   chk_sticky_set: assert property (xfer_done |=>
      (ctrl_q[7:6] & $past(ctrl_q[7:6])) == $past(ctrl_q[7:6])) else $error("host cleared");
   chk_req_success: assert property (ifr_success && !xfer_done |=> !ctrl_q[7])
      else $error("request kept after success");
   chk_req_idle: assert property (bus_idle_det && !xfer_done |=> !ctrl_q[7])
      else $error("request kept after idle");
   chk_skip_enter: assert property (xfer_done && ctrl_byte[5] |->
      ##[1:2] (idle_pin_q && unsol_hold_q)) else $error("skip not entered");
   chk_skip_hold: assert property (hold_q > 8'h01 && hold_q < 8'h78 |-> idle_pin_q)
      else $error("idle pin dropped early");
   chk_pd_refuse: assert property (xfer_done && ctrl_byte[4] && idle_pin_q &&
      !codec_passive_q && !ctrl_q[4] |=> !ctrl_q[4]) else $error("power down accepted");
   chk_hs_break: assert property (break_det && !xfer_done |=> !ctrl_q[3])
      else $error("high speed kept after break");
   chk_hs_refuse: assert property (xfer_done && first_after_break && !ctrl_q[3]
      |=> !ctrl_q[3]) else $error("high speed set after break");
   chk_multi_alone: assert property (!ctrl_q[7] && !$past(ctrl_q[7]) |->
      !ifr_enable_q) else $error("response without request");
endmodule // vlc_props
bind vlc_link_control vlc_props u_props (.clk, .resetn, .xfer_done, .first_after_break,
   .bus_idle_det, .ifr_success, .break_det, .ifr_enable_q, .idle_pin_q, .unsol_hold_q,
   .codec_passive_q, .ctrl_byte, .ctrl_q, .div_ratio_q);

// ### verification/vlc_host_model.sv
/* host model: runs one control exchange per go pulse.
 assumes go is a one-cycle pulse from the bench. */
`timescale 1ns/10ps
module vlc_host_model (
   input  wire       clk, go,
   input  wire [7:0] data,
   output reg        xfer_done,
   output reg  [7:0] ctrl_byte
);
   initial xfer_done = 1'b0;
   initial ctrl_byte = 8'h00;
   always @(posedge clk) begin
      xfer_done <= go;
      ctrl_byte <= go ? data : ~ctrl_byte;
   end
endmodule // vlc_host_model

// ### verification/vpw_link_control_register_bench.sv
/* bench: scenarios on the link control register with the host model.
 assumes a 20 mhz clock and sync active-low reset. */
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_compared = n_compared + 1; if ((a) !== (e)) begin \
   bad_count = bad_count + 1; $display("[ERR] %s exp %h got %h", n, e, a); end end
module vpw_link_control_register_bench;
   localparam [39:0] DT = {5'h01, 5'h02, 5'h04, 5'h08, 5'h05, 5'h0a, 5'h06, 5'h0c};
   reg        clk, resetn, go, fab, bsi, bri;
   reg  [7:0] data;
   reg  [5:0] ev;
   wire       xd, ie, im, ms, tb, hs, ip, uh, cp, cg, tk;
   wire [7:0] cb, c;
   wire [4:0] dv;
   int        bad_count, n_compared, cyc, s;
   vlc_host_model u_host (.clk(clk), .go(go), .data(data), .xfer_done(xd), .ctrl_byte(cb));
   vlc_link_control u_dut (.clk(clk), .resetn(resetn), .xfer_done(xd), .ctrl_byte(cb),
      .first_after_break(fab), .bus_idle_det(ev[0]), .ifr_success(ev[1]), .arb_lost(ev[2]),
      .break_det(ev[3]), .rx_edge(ev[4]), .pd_abort(ev[5]), .bus_symbol_in(bsi),
      .exch_req_in(1'b0), .byte_ready_in(bri), .ctrl_q(c), .ifr_enable_q(ie),
      .ifr_multi_q(im), .multi_status_q(ms), .tx_blocked_q(tb), .hs_active_q(hs),
      .idle_pin_q(ip), .unsol_hold_q(uh), .codec_passive_q(cp), .clk_gate_q(cg),
      .div_ratio_q(dv), .tick_q(tk));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task end_sim;
      if (bad_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         end_sim;
      end
   end
   task w(input int n); repeat (n) @(posedge clk); #1; endtask
   task ex(input [7:0] d);
      @(posedge clk); go <= 1'b1; data <= d;
      @(posedge clk); go <= 1'b0;
      w(3);
   endtask
   task pe(input int i);
      @(posedge clk); ev[i] <= 1'b1;
      @(posedge clk); ev[i] <= 1'b0;
      w(2);
   endtask
   task rst;
      @(posedge clk); resetn <= 1'b0;
      w(12);
      `CHK("ctrl", 8'h00, c)
      `CHK("div", 5'h10, dv)
      `CHK("passive", 1'b1, cp)
      @(posedge clk); resetn <= 1'b1;
   endtask
   task t_div;
      for (s = 0; s < 8; s++) begin
         rst;
         ex(s[7:0]);
         `CHK("div", DT[s * 5 +: 5], dv)
      end
      `CHK("passive", 1'b0, cp)
   endtask
   task t_skip;
      ex(8'h27);
      `CHK("idle", 1'b1, ip)
      `CHK("unsol", 1'b1, uh)
      ex(8'h17);
      `CHK("pdown", 1'b0, c[4])
      w(100);
      `CHK("idle", 1'b1, ip)
      w(30);
      `CHK("idle", 1'b0, ip)
      `CHK("skip", 1'b0, c[5])
   endtask
   task t_pd;
      ex(8'h17);
      `CHK("pdown", 1'b1, c[4])
      `CHK("gate", 1'b1, cg)
      `CHK("tick", 1'b0, tk)
      @(posedge clk); bri <= 1'b1;
      w(8);
      `CHK("pdown", 1'b0, c[4])
      `CHK("tick", 1'b1, tk)
      `CHK("div", 5'h01, dv)
      @(posedge clk); bri <= 1'b0;
      w(50);
   endtask
   task t_hs;
      ex(8'h0f);
      `CHK("hs", 1'b1, c[3])
      pe(4);
      `CHK("hs", 1'b1, hs)
      pe(3);
      `CHK("hs", 1'b0, c[3])
      pe(4);
      `CHK("hs", 1'b0, hs)
      pe(0);
      `CHK("idle", 1'b0, ip)
      @(posedge clk); fab <= 1'b1;
      ex(8'h0f);
      `CHK("hs", 1'b0, c[3])
      @(posedge clk); fab <= 1'b0;
      ex(8'h0f);
      `CHK("hs", 1'b1, c[3])
      ex(8'h07);
      `CHK("hs", 1'b0, c[3])
   endtask
   task t_req;
      ex(8'h87);
      `CHK("req", 1'b1, c[7])
      ex(8'h07);
      `CHK("req", 1'b1, c[7])
      pe(1);
      `CHK("req", 1'b0, c[7])
      // multi set without request, enable and multi output kept low
      ex(8'h47);
      `CHK("enable", 1'b0, ie)
      `CHK("mstat", 1'b1, ms)
      `CHK("multi", 1'b0, im)
      ex(8'h87);
      `CHK("enable", 1'b1, ie)
      `CHK("multi", 1'b1, im)
      pe(2);
      `CHK("blocked", 1'b1, tb)
      `CHK("enable", 1'b0, ie)
      pe(0);
      `CHK("req", 1'b0, c[7])
      `CHK("multi_byte_response", 1'b0, c[6])
      `CHK("blocked", 1'b0, tb)
   endtask
   initial begin
      resetn = 1'b0; go = 1'b0; fab = 1'b0; bsi = 1'b1; bri = 1'b0;
      data = 8'h00; ev = 6'h00; bad_count = 0; n_compared = 0; cyc = 0;
      t_div;
      t_skip;
      t_pd;
      t_hs;
      t_req;
      end_sim;
   end
endmodule // vpw_link_control_register_bench
